// ---- fifo_cascade_pkg.sv ----
// Shared constants for the depth-cascaded first-word-fall-through FIFO chain.
// Assumes a single 100 MHz system clock; slower clocks arrive as one-cycle enables.
package fifo_cascade_pkg;
  // Data word and cascade shape defaults
  localparam int WORD_WIDTH = 18;
  localparam int UNIT_DEPTH = 8192;
  localparam int UNIT_COUNT = 2;
  // Width of the small tick counters used for fall-through and vacancy delays
  localparam int TICK_W = 3;
  // Ticks for a first word to appear at a unit output (link side and read side)
  localparam logic [TICK_W-1:0] FALL_TICKS_LINK = 3'h4;
  localparam logic [TICK_W-1:0] FALL_TICKS_READ = 3'h3;
  // Ticks for a freed slot to show as input ready (link side and write side)
  localparam logic [TICK_W-1:0] VAC_TICKS_LINK = 3'h3;
  localparam logic [TICK_W-1:0] VAC_TICKS_WRITE = 3'h2;
  // Reset values of the per-unit flags
  localparam logic RDY_RESET = 1'h1;
  localparam logic OV_RESET = 1'h0;
endpackage : fifo_cascade_pkg

// ---- cascade_unit_mem.sv ----
// Simple dual-port word store for one cascade unit, read data held in a register.
// Assumes the caller never reads an address in the cycle it writes it.
`timescale 1ns/1ps
`default_nettype none
module cascade_unit_mem #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8192,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata_r
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Storage has no reset so it can map onto block memory
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Output word register, which is also the unit's visible data
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= '0;
    end else if (re) begin
      rdata_r <= mem[raddr];
    end
  end
endmodule : cascade_unit_mem
`default_nettype wire

// ---- fifo_depth_cascade_chain.sv ----
// Depth cascade of first-word-fall-through FIFO units behaving as one deep FIFO.
// Assumes write, read and transfer clocks arrive as one-cycle enables on sys_clk,
// driven by same-domain logic, so no synchronisers are needed on them.
// Each unit keeps its own pointers, occupancy and two small delay counters.
// Limitation: only depth cascading is built; width expansion is left to the system.
`timescale 1ns/1ps
`default_nettype none
module fifo_depth_cascade_chain #(
  parameter int WIDTH = fifo_cascade_pkg::WORD_WIDTH,
  parameter int DEPTH = fifo_cascade_pkg::UNIT_DEPTH,
  parameter int UNITS = fifo_cascade_pkg::UNIT_COUNT
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wr_clk_en,
  input wire logic xfer_clk_en,
  input wire logic rd_clk_en,
  input wire logic wr_en_n,
  input wire logic [WIDTH-1:0] wr_data,
  output logic input_ready_n,
  input wire logic rd_en_n,
  output logic [WIDTH-1:0] rd_data,
  output logic output_valid_n
);
  import fifo_cascade_pkg::*;

  // Address width, and a counter width with headroom for the occupancy sum
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 2;

  // Pointers wrap naturally only for power-of-two depths
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo_depth_cascade_chain: DEPTH must be a power of two, at least 2");
  end

  // A chain needs at least one unit to hold anything
  if (UNITS < 1) begin : g_bad_units
    $error("fifo_depth_cascade_chain: UNITS must be at least 1");
  end

  // Zero-width words make no sense on the data path
  if (WIDTH < 1) begin : g_bad_width
    $error("fifo_depth_cascade_chain: WIDTH must be at least 1");
  end

  // Tick counters compare against delay minus one, so no delay may be zero
  if (FALL_TICKS_LINK == '0 || FALL_TICKS_READ == '0 ||
      VAC_TICKS_LINK == '0 || VAC_TICKS_WRITE == '0) begin : g_bad_ticks
    $error("fifo_depth_cascade_chain: tick delays must be nonzero");
  end

  // Per-unit state; cnt counts words in store only, ov tracks the output register
  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] cnt;
    logic ov;
    logic rdy;
    logic [TICK_W-1:0] fcnt;
    logic [TICK_W-1:0] icnt;
  } unit_state_t;

  // One state word per unit, plus the handshake and data nets between neighbours
  unit_state_t st_r [UNITS];
  unit_state_t st_nxt [UNITS];
  logic [UNITS-1:0] wtick;
  logic [UNITS-1:0] rtick;
  logic [UNITS-1:0] wreq;
  logic [UNITS-1:0] rreq;
  logic [UNITS-1:0] do_wr;
  logic [UNITS-1:0] do_load;
  logic [UNITS-1:0] do_rd;
  logic [WIDTH-1:0] din [UNITS];
  logic [WIDTH-1:0] dout [UNITS];

  for (genvar k = 0; k < UNITS; k++) begin : g_unit
    // Per-unit delay lengths, picked by where the unit sits in the chain
    logic [TICK_W-1:0] fall_ticks;
    logic [TICK_W-1:0] vac_ticks;
    logic fall_done;
    logic refill;

    // Write side: first unit takes the producer, others take the link
    if (k == 0) begin : g_head
      assign wtick[k] = wr_clk_en;
      assign wreq[k] = ~wr_en_n;
      assign din[k] = wr_data;
      assign vac_ticks = VAC_TICKS_WRITE;
    end else begin : g_link_in
      assign wtick[k] = xfer_clk_en;
      assign wreq[k] = st_r[k-1].ov;
      assign din[k] = dout[k-1];
      assign vac_ticks = VAC_TICKS_LINK;
    end

    // Read side: last unit faces the consumer, others feed the link
    if (k == UNITS - 1) begin : g_tail
      assign rtick[k] = rd_clk_en;
      assign rreq[k] = ~rd_en_n;
      assign fall_ticks = FALL_TICKS_READ;
    end else begin : g_link_out
      assign rtick[k] = xfer_clk_en;
      assign rreq[k] = st_r[k+1].rdy;
      assign fall_ticks = FALL_TICKS_LINK;
    end

    // Handshakes: a link transfer is one tick seen by both neighbours at once
    assign do_wr[k] = wtick[k] & wreq[k] & st_r[k].rdy;

    // The read side hands on a word only while one is held at the output
    assign do_rd[k] = rtick[k] & rreq[k] & st_r[k].ov;

    // Fall-through delay has run out for the word waiting in store
    assign fall_done = !st_r[k].ov && (st_r[k].fcnt == fall_ticks - 3'h1);

    // A read of the output word pulls the next stored word in on the same tick
    assign refill = st_r[k].ov && do_rd[k];

    // Load the output register on a refill read, or without a read once the fall-through delay is done
    assign do_load[k] = rtick[k] && (st_r[k].cnt != '0) && (refill || fall_done);

    // Next-state for one unit: pointers, occupancy and the two delayed flags
    always_comb begin
      logic [CW-1:0] total;
      logic [CW-1:0] total_nxt;
      total = '0;
      total_nxt = '0;
      st_nxt[k] = st_r[k];
      // Pointers step on a write into store and on a load into the output register
      st_nxt[k].wptr = st_r[k].wptr + AW'(do_wr[k]);
      st_nxt[k].rptr = st_r[k].rptr + AW'(do_load[k]);
      st_nxt[k].cnt = st_r[k].cnt + (AW+1)'(do_wr[k]) - (AW+1)'(do_load[k]);

      // Output valid is a word held in the output register
      if (do_load[k]) begin
        st_nxt[k].ov = 1'b1;
      end else if (do_rd[k]) begin
        st_nxt[k].ov = 1'b0;
      end

      // Fall-through counter only runs while the output is empty
      if (do_load[k] || st_r[k].ov || st_r[k].cnt == '0) begin
        st_nxt[k].fcnt = '0;
      end else if (rtick[k]) begin
        st_nxt[k].fcnt = st_r[k].fcnt + 3'h1;
      end

      // Capacity counts both stored words and the output register
      total = CW'(st_r[k].cnt) + CW'(st_r[k].ov);
      total_nxt = CW'(st_nxt[k].cnt) + CW'(st_nxt[k].ov);
      // Ready drops on the edge that fills the unit, so no write slips in late
      if (total_nxt >= CW'(DEPTH)) begin
        st_nxt[k].rdy = 1'b0;
        st_nxt[k].icnt = '0;
      end else if (!st_r[k].rdy && total < CW'(DEPTH) && wtick[k]) begin
        // A freed slot shows after a fixed number of write-side ticks
        if (st_r[k].icnt == vac_ticks - 3'h1) begin
          st_nxt[k].rdy = 1'b1;
          st_nxt[k].icnt = '0;
        end else begin
          st_nxt[k].icnt = st_r[k].icnt + 3'h1;
        end
      end
    end

    // Unit state register; enables alone gate progress, so any enable may stop
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        st_r[k] <= '{
          wptr: '0,
          rptr: '0,
          cnt: '0,
          ov: OV_RESET,
          rdy: RDY_RESET,
          fcnt: '0,
          icnt: '0
        };
      end else begin
        st_r[k] <= st_nxt[k];
      end
    end

    // Word store with the unit's output register inside
    // A load only reads a word already counted, so it never meets a write to one address
    cascade_unit_mem #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH),
      .AW(AW)
    ) u_mem (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .we(do_wr[k]),
      .waddr(st_r[k].wptr),
      .wdata(din[k]),
      .re(do_load[k]),
      .raddr(st_r[k].rptr),
      .rdata_r(dout[k])
    );
  end

  // Chain ends: flags are register bits, data is the last output register,
  // so no glitch from the unit logic reaches the producer or the consumer
  assign input_ready_n = ~st_r[0].rdy;
  assign output_valid_n = ~st_r[UNITS-1].ov;

  // Data comes straight from the last unit's output register
  assign rd_data = dout[UNITS-1];
endmodule : fifo_depth_cascade_chain
`default_nettype wire

// ---- placeholder_end.sv ----
// Intentionally empty compile unit marker; holds no logic.
// Assumes nothing of its surroundings.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- chain_checker_assertions.sv ----
// Port checker for the cascade chain.
// Assumes one clock and a bind onto the chain.
`timescale 1ns/1ps
`default_nettype none
module chain_checker #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8192,
  parameter int UNITS = 2
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wr_clk_en,
  input wire logic xfer_clk_en,
  input wire logic rd_clk_en,
  input wire logic wr_en_n,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic input_ready_n,
  input wire logic rd_en_n,
  input wire logic [WIDTH-1:0] rd_data,
  input wire logic output_valid_n
);
  wire logic wr_tk = wr_clk_en && !wr_en_n && !input_ready_n;
  wire logic rd_tk = rd_clk_en && !rd_en_n && !output_valid_n;
  wire logic calm = wr_clk_en && xfer_clk_en && rd_clk_en && wr_en_n;
  int cnt_r;
  // Words held, so flags can be judged without seeing inside
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) cnt_r <= 0;
    else cnt_r <= cnt_r + int'(wr_tk) - int'(rd_tk);
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_first;
    wr_tk && cnt_r == 0 && xfer_clk_en && rd_clk_en && rd_en_n;
  endsequence
  sequence s_quiet;
    wr_clk_en && xfer_clk_en && rd_clk_en && rd_en_n;
  endsequence
  a_reset_flags: assert property ($rose(reset_n) |-> !input_ready_n && output_valid_n)
    else $error("flags wrong after reset");
  a_valid_holds: assert property (!output_valid_n && !rd_tk |=> !output_valid_n)
    else $error("valid dropped without read");
  a_data_holds: assert property (!output_valid_n && !rd_tk |=> $stable(rd_data))
    else $error("word changed without read");
  a_empty_quiet: assert property (cnt_r == 0 |-> output_valid_n)
    else $error("valid with nothing stored");
  a_full_refuses: assert property (cnt_r == UNITS * DEPTH |-> input_ready_n)
    else $error("ready beyond capacity");
  a_last_read: assert property (rd_tk && cnt_r == 1 |=> output_valid_n)
    else $error("valid after last word");
  a_ripple_bound: assert property (s_first ##1 s_quiet[*8] ##1 s_quiet[*3] |-> !output_valid_n)
    else $error("first word too slow");
  a_vacancy_bound: assert property (rd_tk && input_ready_n && calm ##1 calm[*8] ##1 calm[*2] |-> !input_ready_n)
    else $error("vacancy too slow");
endmodule : chain_checker
bind fifo_depth_cascade_chain chain_checker #(.WIDTH(WIDTH), .DEPTH(DEPTH), .UNITS(UNITS)) chk (.sys_clk,
  .reset_n, .wr_clk_en, .xfer_clk_en, .rd_clk_en, .wr_en_n, .wr_data, .input_ready_n, .rd_en_n, .rd_data,
  .output_valid_n);
`default_nettype wire

// ---- drain_side.sv ----
// Consumer at the last unit: reads unless stalled.
// Assumes stall changes just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module drain_side (
  input wire logic sys_clk,
  input wire logic stall,
  input wire logic rd_clk_en,
  input wire logic output_valid_n,
  input wire logic [fifo_cascade_pkg::WORD_WIDTH-1:0] rd_data,
  output logic rd_en_n,
  output logic got,
  output logic [fifo_cascade_pkg::WORD_WIDTH-1:0] got_word
);
  // Request held straight from stall, so reads may run back to back
  assign rd_en_n = stall;
  // Record each taken read; the read ticks keep running meanwhile
  always @(posedge sys_clk) begin
    got <= rd_clk_en && !rd_en_n && !output_valid_n;
    got_word <= rd_data;
  end
endmodule : drain_side
`default_nettype wire

// ---- fifo_depth_cascade_chain_tb.sv ----
// Self-checking bench for a two-unit chain of depth four.
// Assumes the checker is bound and drain_side reads.
`timescale 1ns/1ps
`default_nettype none
module fifo_depth_cascade_chain_tb;
  import fifo_cascade_pkg::*;
  logic sys_clk = 0, reset_n = 0, wr_clk_en = 1, xfer_clk_en = 1, rd_clk_en = 1, wr_en_n = 1, stall = 1;
  logic [WORD_WIDTH-1:0] wr_data = '0, rd_data, got_word, q[$];
  logic input_ready_n, rd_en_n, output_valid_n, got;
  int fail_count = 0, checked = 0, n, k;
  always #5 sys_clk = ~sys_clk;
  fifo_depth_cascade_chain #(.DEPTH(4)) uut (.sys_clk, .reset_n, .wr_clk_en, .xfer_clk_en, .rd_clk_en,
    .wr_en_n, .wr_data, .input_ready_n, .rd_en_n, .rd_data, .output_valid_n);
  drain_side partner (.sys_clk, .stall, .rd_clk_en, .output_valid_n, .rd_data, .rd_en_n, .got, .got_word);
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic check(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      fail_count++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask : check
  // Slack of one cycle per unit plus three above the nominal delay
  function automatic bit near(int v, int base);
    return v >= base && v <= base + UNIT_COUNT + 3;
  endfunction : near
  task automatic wrap_up;
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // Reference queue: pop the word read last edge, then push the one written next
  always @(negedge sys_clk) begin
    if (got === 1'b1) check(q.size() > 0 && got_word === q.pop_front(), "word order");
    if (reset_n && wr_clk_en && !wr_en_n && input_ready_n === 1'b0) q.push_back(wr_data);
  end
  initial begin
    void'($urandom(32'h36C8));
    repeat (6) @(posedge sys_clk);
    #1 reset_n = 1;
    check(input_ready_n === 1'b0 && output_valid_n === 1'b1, "reset flags");
    // First word ripples through the empty chain
    wr_en_n = 0;
    wr_data = 18'h2A5A5;
    tick;
    wr_en_n = 1;
    for (n = 0; output_valid_n !== 1'b0 && n < 40; n++) tick;
    check(near(n, (UNIT_COUNT - 1) * 4 + 3), "ripple delay");
    // Two more back to back; each read shows the next word at once
    wr_en_n = 0;
    repeat (2) begin
      wr_data = WORD_WIDTH'($urandom);
      tick;
    end
    wr_en_n = 1;
    repeat (20) tick;
    stall = 0;
    for (k = 0; k < 3; k++) begin
      tick;
      check(output_valid_n === (k == 2), "next word late");
    end
    stall = 1;
    // Fill until refused; capacity is the sum of both units
    n = 0;
    wr_en_n = 0;
    repeat (60) begin
      wr_data = WORD_WIDTH'($urandom);
      if (input_ready_n === 1'b0) n++;
      tick;
    end
    wr_en_n = 1;
    check(n == UNIT_COUNT * 4 && input_ready_n === 1'b1, "capacity");
    // One read from full; the vacancy climbs back to the first unit
    stall = 0;
    tick;
    stall = 1;
    for (n = 0; input_ready_n !== 1'b0 && n < 40; n++) tick;
    check(near(n, (UNIT_COUNT - 1) * 3 + 2), "vacancy delay");
    // Keep every rate running so the vacancy bound assertion sees its whole window
    repeat (4) tick;
    // Unrelated, sometimes stopped, write and read rates
    repeat (1500) begin
      wr_clk_en = 1'($urandom);
      rd_clk_en = 1'($urandom);
      xfer_clk_en = wr_clk_en | rd_clk_en;
      wr_en_n = 1'($urandom);
      wr_data = WORD_WIDTH'($urandom);
      stall = 1'($urandom);
      tick;
    end
    // Drain: no more writes, all rates running, consumer reading every tick
    {wr_en_n, wr_clk_en, rd_clk_en, xfer_clk_en, stall} = 5'h1E;
    repeat (200) tick;
    check(q.size() == 0 && output_valid_n === 1'b1, "not drained");
    wrap_up;
  end
  initial begin
    #100us;
    fail_count++;
    wrap_up;
  end
endmodule : fifo_depth_cascade_chain_tb
`default_nettype wire
